// [logic/mrsp_controller.sv]
// Controller end: AXI4-Lite registers that issue mode-register commands over the link.
`timescale 1ns/1ps
`include "mrsp_cfg.svh"
module mrsp_controller
  import mrsp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  mrsp_link_if.controller  link,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  mrsp_state_type state_reg;       // Command sequencer state.
  logic           wr_take;         // Address and data taken together.
  logic           cmd_hit;         // Write to the command register.
  logic [31:0]    wmask;           // Byte-lane mask from the strobes.
  logic [31:0]    cmd_reg;         // Pending command word.
  logic [13:0]    ctrl_reg;        // Clock enable and CA pattern.
  logic           cke_force_reg;   // Clock enable held high by the sequencer.
  logic           trn_shadow_reg;  // Last training bit written.
  logic           msk_shadow_reg;  // Last mask-disable bit written.
  logic           refused_reg;     // Last masked write refused.
  logic [7:0]     rdata_reg;       // Last read answer.
  logic [5:0]     capture_reg;     // Last training echo seen.
  logic           bvalid_reg;      // Write response pending.
  logic [1:0]     bresp_reg;       // Write response code.
  logic           rvalid_reg;      // Read response pending.
  logic [31:0]    rdata_out_reg;   // Read response data.
  logic [1:0]     rresp_reg;       // Read response code.

  // Both write channels are taken in one cycle, and only once no response is owed.
  assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = !rvalid_reg;
  assign cmd_hit       = wr_take && (s_axi_awaddr == `MRSP_OFF_CMD);

  // Expand the byte strobes into a bit mask, one lane per byte.
  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end
  endgenerate

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `MRSP_RESP_OKAY;
    end else if (wr_take) begin
      bvalid_reg <= 1'b1;
      if ((s_axi_awaddr == `MRSP_OFF_CMD) || (s_axi_awaddr == `MRSP_OFF_CTRL)) begin
        bresp_reg <= `MRSP_RESP_OKAY;
      end else begin
        bresp_reg <= `MRSP_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Control register: clock enable in bit 0, CA pattern in bits 13:8.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 14'h0001;
    end else if (wr_take && (s_axi_awaddr == `MRSP_OFF_CTRL)) begin
      // Only lanes with their strobe set change; the others keep their bits.
      ctrl_reg <= (s_axi_wdata[13:0] & wmask[13:0]) | (ctrl_reg & ~wmask[13:0]);
    end
  end

  // Command sequencer. A command written while busy is dropped; software polls busy.
  // In bus training with clock enable low, every command would be ignored, so the
  // sequencer raises clock enable one cycle before it issues and holds it high until it is back in idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= MRSP_IDLE;
      cmd_reg       <= 32'h0000_0000;
      cke_force_reg <= 1'b0;
      refused_reg   <= 1'b0;
    end else begin
      case (state_reg)
        MRSP_IDLE: begin
          cke_force_reg <= 1'b0;
          if (cmd_hit) begin
            cmd_reg <= s_axi_wdata;
            if (s_axi_wdata[17] && msk_shadow_reg) begin
              refused_reg <= 1'b1;
            end else if (trn_shadow_reg && !ctrl_reg[0]) begin
              refused_reg   <= 1'b0;
              cke_force_reg <= 1'b1;
              state_reg     <= MRSP_RAISE;
            end else begin
              refused_reg <= 1'b0;
              state_reg   <= MRSP_ISSUE;
            end
          end
        end
        MRSP_RAISE: begin
          state_reg <= MRSP_ISSUE;
        end
        MRSP_ISSUE: begin
          if (cmd_reg[16] || cmd_reg[17]) begin
            state_reg <= MRSP_IDLE;
          end else begin
            state_reg <= MRSP_WAIT;
          end
        end
        MRSP_WAIT: begin
          if (link.dq_valid) begin
            state_reg <= MRSP_IDLE;
          end
        end
        default: begin
          state_reg <= MRSP_IDLE;
        end
      endcase
    end
  end

  // Shadows of the device's control bits, taken from every issued write to the training register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trn_shadow_reg <= 1'b0;
      msk_shadow_reg <= 1'b0;
    end else if ((state_reg == MRSP_ISSUE) && cmd_reg[16] && !cmd_reg[17] &&
                 (cmd_reg[13:8] == `MRSP_ADDR_TRAIN)) begin
      trn_shadow_reg <= cmd_reg[`MRSP_BIT_CA_TRAIN];
      msk_shadow_reg <= cmd_reg[`MRSP_BIT_MASK_OFF];
    end
  end

  // Read answers and training echoes are captured for software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg   <= 8'h00;
      capture_reg <= 6'h00;
    end else if (link.dq_valid) begin
      rdata_reg <= link.dq_out;
    end else if (link.dq_oe) begin
      capture_reg <= link.dq_out[5:0];
    end
  end

  // Link drive: the whole operand byte goes out in one write, range and level together.
  assign link.cmd_valid     = (state_reg == MRSP_ISSUE);
  assign link.cmd_write     = cmd_reg[16];
  assign link.cmd_masked_wr = cmd_reg[17];
  assign link.cmd_addr      = cmd_reg[13:8];
  assign link.cmd_op        = cmd_reg[7:0];
  assign link.cke           = ctrl_reg[0] || cke_force_reg;
  assign link.ca            = ctrl_reg[13:8];

  // Read channel: status holds busy, refused flag, read data and echo capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg    <= 1'b0;
      rdata_out_reg <= 32'h0000_0000;
      rresp_reg     <= `MRSP_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `MRSP_RESP_OKAY;
      if (s_axi_araddr == `MRSP_OFF_CMD) begin
        rdata_out_reg <= cmd_reg;
      end else if (s_axi_araddr == `MRSP_OFF_CTRL) begin
        rdata_out_reg <= {18'h00000, ctrl_reg};
      end else if (s_axi_araddr == `MRSP_OFF_STATUS) begin
        rdata_out_reg <= {10'h000, capture_reg, rdata_reg, 6'h00, refused_reg, (state_reg != MRSP_IDLE)};
      end else begin
        rdata_out_reg <= 32'h0000_0000;
        rresp_reg     <= `MRSP_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_out_reg;
  assign s_axi_rresp  = rresp_reg;
endmodule : mrsp_controller

// [logic/mrsp_device.sv]
// Device end: training control register, dual set-point data reference and mode-register command handling.
//
// Notes on behaviour
// - Bit 0 enters command-bus training mode.
// - Training with clock enable low echoes CA.
// - Controller raises clock enable before clearing training.
// - Bit 1 enables read preamble training.
// - Bit 2 outputs active reference levels.
// - Bit 3 selects fast-response reference mode.
// - Option zero reports 011 for 001/010.
// - Option applies only when info bit set.
// - Controller follows reported refresh mode; this controller never reads the report.
// - Bit 5 disables masking; masked writes illegal.
// - Bit 6 picks set point for writes.
// - Bit 7 picks operating set point.
// - Training register fields all reset zero.
// - Level code, range bit, reserved bit.
// - Level codes above 110010 are reserved.
// - Read returns eight bits, reserved zero.
// - Accesses reach write-selected copy only.
// - Only operating copy governs operation.
// - Range kept until overwritten or reset.
// - Controller writes range with level together.
// - Level resets to 001101 in range 1.
`timescale 1ns/1ps
`include "mrsp_cfg.svh"
module mrsp_device
  import mrsp_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  mrsp_link_if.device     link,
  input  wire logic       base_info_bit0,
  input  wire logic [2:0] refresh_rate_raw,
  input  wire logic [5:0] cmd_ref_level_sp0,
  input  wire logic [5:0] cmd_ref_level_sp1,
  output logic [2:0]      refresh_rate_report,
  output logic            command_bus_training,
  output logic            read_preamble_training,
  output logic            reference_output_enable,
  output logic            reference_fast_response,
  output logic            data_mask_disable,
  output logic            write_set_point_select,
  output logic            operating_set_point_select,
  output logic [5:0]      ref_probe_command_level,
  output logic [5:0]      ref_probe_data_level,
  output logic [5:0]      data_ref_level,
  output logic            data_ref_range,
  output logic            masked_write_ok,
  output logic            illegal_masked_write,
  output logic            dref_write_refused
);
  logic [7:0]    train_reg;        // Training and set-point control register.
  logic          cmd_blocked;      // Commands ignored while echoing CA.
  logic          wr_cmd_take;      // Mode-register write accepted this cycle.
  logic          rd_cmd_take;      // Mode-register read accepted this cycle.
  logic          dref_wr;          // Write that lands in a data-reference copy.
  logic          level_ok;         // Written level code is in the valid range.
  mrsp_dref_type dref_acc;         // Copy seen by accesses.
  mrsp_dref_type dref_op;          // Copy that governs operation.
  logic [7:0]    dq_reg;           // Registered data bus value.
  logic          dq_oe_reg;        // Registered data bus drive enable.
  logic          dq_valid_reg;     // Registered read answer strobe.
  logic [2:0]    rr_reg;           // Registered refresh-rate report.
  logic          illegal_reg;      // Registered illegal masked write flag.
  logic          refused_reg;      // Registered refused data-reference write.

  // While training and clock enable is low, the command decoder is shut off and
  // the CA pins are only mirrored; this is why the controller must raise clock
  // enable before the write that ends training.
  assign cmd_blocked = train_reg[`MRSP_BIT_CA_TRAIN] && !link.cke;

  // Command decode for the two accepted command kinds.
  assign wr_cmd_take = link.cmd_valid && link.cmd_write && !link.cmd_masked_wr && !cmd_blocked;
  assign rd_cmd_take = link.cmd_valid && !link.cmd_write && !link.cmd_masked_wr && !cmd_blocked;

  // Only codes 000000 through 110010 are accepted for the level field.
  assign level_ok = (link.cmd_op[5:0] <= `MRSP_LEVEL_MAX);
  assign dref_wr  = wr_cmd_take && (link.cmd_addr == `MRSP_ADDR_DREF) && level_ok;

  // Training control register: write-only, every field clears on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      train_reg <= `MRSP_TRAIN_RESET;
    end else if (wr_cmd_take && (link.cmd_addr == `MRSP_ADDR_TRAIN)) begin
      // Both select bits land in the same edge, so the next access already uses them.
      train_reg <= link.cmd_op;
    end
  end

  // Dual set-point storage; level and range arrive in one write and are kept together.
  mrsp_set_point_pair u_dref (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (dref_wr),
    .wr_sel   (train_reg[`MRSP_BIT_WSP]),
    .wr_data  (link.cmd_op[6:0]),
    .acc_data (dref_acc),
    .op_data  (dref_op),
    .op_sel   (train_reg[`MRSP_BIT_OSP])
  );

  // Data bus: training echo has priority, then read answers. The echo is held
  // for as long as the blocked condition lasts, with one cycle of latency.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_reg       <= 8'h00;
      dq_oe_reg    <= 1'b0;
      dq_valid_reg <= 1'b0;
    end else if (cmd_blocked) begin
      dq_reg       <= {2'b00, link.ca};
      dq_oe_reg    <= 1'b1;
      dq_valid_reg <= 1'b0;
    end else if (rd_cmd_take) begin
      // Only the data-reference register can be read; any other address answers zero.
      if (link.cmd_addr == `MRSP_ADDR_DREF) begin
        dq_reg <= {1'b0, dref_acc};
      end else begin
        dq_reg <= 8'h00;
      end
      dq_oe_reg    <= 1'b1;
      dq_valid_reg <= 1'b1;
    end else begin
      dq_reg       <= 8'h00;
      dq_oe_reg    <= 1'b0;
      dq_valid_reg <= 1'b0;
    end
  end

  assign link.dq_out   = dq_reg;
  assign link.dq_oe    = dq_oe_reg;
  assign link.dq_valid = dq_valid_reg;

  // Refresh-rate reporting: with the option cleared, the two low codes are
  // folded into 011, but only on parts whose info bit enables the option.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rr_reg <= 3'h0;
    end else if (base_info_bit0 && !train_reg[`MRSP_BIT_RATE_OPT] &&
                 ((refresh_rate_raw == `MRSP_RR_LOW_A) || (refresh_rate_raw == `MRSP_RR_LOW_B))) begin
      rr_reg <= `MRSP_RR_SUBST;
    end else begin
      rr_reg <= refresh_rate_raw;
    end
  end

  assign refresh_rate_report = rr_reg;

  // Masked writes are legal only with masking enabled; an attempt with masking
  // disabled is flagged for one cycle and otherwise has no effect here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_reg <= 1'b0;
    end else begin
      illegal_reg <= link.cmd_valid && link.cmd_masked_wr && train_reg[`MRSP_BIT_MASK_OFF];
    end
  end

  assign illegal_masked_write = illegal_reg;
  assign masked_write_ok      = !train_reg[`MRSP_BIT_MASK_OFF];

  // A write with a reserved level code is dropped whole, so a stray code can
  // never reach the reference generator; the drop is reported as a pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= wr_cmd_take && (link.cmd_addr == `MRSP_ADDR_DREF) && !level_ok;
    end
  end

  assign dref_write_refused = refused_reg;

  // Mode outputs taken straight from the control register.
  assign command_bus_training       = train_reg[`MRSP_BIT_CA_TRAIN];
  assign read_preamble_training     = train_reg[`MRSP_BIT_PRE_TRAIN];
  assign reference_output_enable    = train_reg[`MRSP_BIT_REF_OUT];
  assign reference_fast_response    = train_reg[`MRSP_BIT_REF_FAST];
  assign data_mask_disable          = train_reg[`MRSP_BIT_MASK_OFF];
  assign write_set_point_select     = train_reg[`MRSP_BIT_WSP];
  assign operating_set_point_select = train_reg[`MRSP_BIT_OSP];

  // Operating data reference comes only from the active copy.
  assign data_ref_level = dref_op[5:0];
  assign data_ref_range = dref_op[`MRSP_DREF_RANGE_BIT];

  // Reference probe: the active set point's levels, zero when output is off.
  // The analog levels are stood in for by their codes.
  always_comb begin
    ref_probe_command_level = 6'h00;
    ref_probe_data_level    = 6'h00;
    if (train_reg[`MRSP_BIT_REF_OUT]) begin
      if (train_reg[`MRSP_BIT_OSP]) begin
        ref_probe_command_level = cmd_ref_level_sp1;
      end else begin
        ref_probe_command_level = cmd_ref_level_sp0;
      end
      ref_probe_data_level = dref_op[5:0];
    end
  end
endmodule : mrsp_device

// [logic/mrsp_set_point_pair.sv]
// Two set-point copies of the data-reference register with separate write and operating selects.
`timescale 1ns/1ps
`include "mrsp_cfg.svh"
module mrsp_set_point_pair
  import mrsp_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          wr_en,
  input  wire logic          wr_sel,
  input  wire mrsp_dref_type wr_data,
  output mrsp_dref_type      acc_data,
  output mrsp_dref_type      op_data,
  input  wire logic          op_sel
);
  mrsp_dref_type copy_reg [2]; // Set point 0 and set point 1 copies.

  // Each copy loads only when the write select names it, so the idle copy may be
  // rewritten freely while the other one governs operation.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_copy
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          copy_reg[i] <= `MRSP_DREF_RESET;
        end else if (wr_en && (wr_sel == 1'(i))) begin
          copy_reg[i] <= wr_data;
        end
      end
    end
  endgenerate

  // Accesses see the write-selected copy.
  assign acc_data = copy_reg[wr_sel];
  // Operation sees only the operating copy.
  assign op_data  = copy_reg[op_sel];
endmodule : mrsp_set_point_pair

// [shared/mrsp_cfg.svh]
// Constants for the mode-register set-point block: addresses, fields, resets and controller register map.
`ifndef MRSP_CFG_SVH
`define MRSP_CFG_SVH
`define MRSP_ADDR_TRAIN     6'h0d
`define MRSP_ADDR_DREF      6'h0e
`define MRSP_TRAIN_RESET    8'h00
`define MRSP_BIT_CA_TRAIN   0
`define MRSP_BIT_PRE_TRAIN  1
`define MRSP_BIT_REF_OUT    2
`define MRSP_BIT_REF_FAST   3
`define MRSP_BIT_RATE_OPT   4
`define MRSP_BIT_MASK_OFF   5
`define MRSP_BIT_WSP        6
`define MRSP_BIT_OSP        7
`define MRSP_DREF_RESET     7'h4d
`define MRSP_DREF_RANGE_BIT 6
`define MRSP_LEVEL_MAX      6'h32
`define MRSP_RR_LOW_A       3'h1
`define MRSP_RR_LOW_B       3'h2
`define MRSP_RR_SUBST       3'h3
`define MRSP_OFF_CMD        32'h0000_0000
`define MRSP_OFF_CTRL       32'h0000_0004
`define MRSP_OFF_STATUS     32'h0000_0008
`define MRSP_RESP_OKAY      2'h0
`define MRSP_RESP_SLVERR    2'h2
`endif

// [shared/mrsp_link_if.sv]
// Command/address and data link between the memory controller and the device mode-register logic.
`timescale 1ns/1ps
interface mrsp_link_if;
  logic       cke;           // Clock enable, high for normal operation.
  logic       cmd_valid;     // One-cycle command strobe.
  logic       cmd_write;     // High for a mode-register write, low for a read.
  logic       cmd_masked_wr; // High marks a masked data write instead of a mode-register access.
  logic [5:0] cmd_addr;      // Mode-register address.
  logic [7:0] cmd_op;        // Write operand.
  logic [5:0] ca;            // Raw command/address pins, echoed during bus training.
  logic [7:0] dq_out;        // Device data bus value.
  logic       dq_oe;         // High while the device drives the data bus.
  logic       dq_valid;      // One-cycle pulse marking read data.
  modport device (input cke, cmd_valid, cmd_write, cmd_masked_wr, cmd_addr, cmd_op, ca,
                  output dq_out, dq_oe, dq_valid);
  modport controller (output cke, cmd_valid, cmd_write, cmd_masked_wr, cmd_addr, cmd_op, ca,
                      input dq_out, dq_oe, dq_valid);
endinterface : mrsp_link_if

// [shared/mrsp_pkg.sv]
// Types shared by both ends of the mode-register set-point link.
package mrsp_pkg;
  // Controller sequencer states, one-hot.
  typedef enum logic [3:0] {
    MRSP_IDLE  = 4'h1,
    MRSP_RAISE = 4'h2,
    MRSP_ISSUE = 4'h4,
    MRSP_WAIT  = 4'h8
  } mrsp_state_type;
  // One stored set-point copy of the data-reference register, reserved bit excluded.
  typedef logic [6:0] mrsp_dref_type;
endpackage : mrsp_pkg

// [verif/dram_mode_reg_set_point_ctl_bench.sv]
// Testbench: AXI4-Lite orders to the controller, device on the far end of the link.
`timescale 1ns/1ps
module dram_mode_reg_set_point_ctl_bench;
  logic        aclk = 0, aresetn = 0, base_bit = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, s;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, rng, mwok, ill, refw;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  rr_raw = 0, rr_rep;
  logic [5:0]  pc, pd, lvl;
  wire  [7:0]  tb;  // Training bits as seen at the device outputs.
  int          bad_count = 0, checks = 0, ill_n = 0, refw_n = 0;
  assign tb[4] = 1'b0;  // The option bit has no output of its own.
  mrsp_link_if link ();
  mrsp_controller mrsp_controller_i (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  mrsp_device mrsp_device_i (.aclk(aclk), .aresetn(aresetn), .link(link), .base_info_bit0(base_bit),
    .refresh_rate_raw(rr_raw), .cmd_ref_level_sp0(6'h15), .cmd_ref_level_sp1(6'h2a),
    .refresh_rate_report(rr_rep), .command_bus_training(tb[0]), .read_preamble_training(tb[1]),
    .reference_output_enable(tb[2]), .reference_fast_response(tb[3]), .data_mask_disable(tb[5]),
    .write_set_point_select(tb[6]), .operating_set_point_select(tb[7]), .ref_probe_command_level(pc),
    .ref_probe_data_level(pd), .data_ref_level(lvl), .data_ref_range(rng), .masked_write_ok(mwok),
    .illegal_masked_write(ill), .dref_write_refused(refw));
  mrsp_link_props mrsp_link_props_i (.aclk(aclk), .aresetn(aresetn), .cke(link.cke),
    .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write), .cmd_masked_wr(link.cmd_masked_wr),
    .cmd_addr(link.cmd_addr), .cmd_op(link.cmd_op), .ca(link.ca), .dq_out(link.dq_out),
    .dq_oe(link.dq_oe), .dq_valid(link.dq_valid));
  initial forever #12.5 aclk = ~aclk;
  // One-cycle pulses are counted, since the tasks return long after they stand.
  always @(posedge aclk) begin
    if (aresetn) begin
      ill_n  <= ill_n + ill;
      refw_n <= refw_n + refw;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Address and data are offered together and held until both are taken.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do @(posedge aclk); while (!(awready && wready));
    {awvalid, wvalid} <= 2'b00;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    s = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Starts one link command, then polls the busy flag; the watchdog ends a hang.
  task automatic mr(input logic [1:0] kind, input logic [5:0] a, input logic [7:0] op);
    axi_wr(32'h0000_0000, {14'h0, kind, 2'b00, a, op});
    do axi_rd(32'h0000_0008); while (s[0] !== 1'b0);
  endtask : mr
  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    #500_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(tb, 8'h00);
    chk({rng, lvl}, 7'h4d);
    mr(2'b00, 6'h0e, 8'h00);
    chk(s[15:8], 8'h4d);
    mr(2'b00, 6'h0d, 8'h00);
    chk(s[15:8], 8'h00);
    axi_rd(32'h0000_0010);
    chk(r, 2'h2);
    axi_wr(32'h0000_000c, 32'h0000_0000);
    chk(r, 2'h2);
    for (int i = 0; i < 8; i++) begin
      mr(2'b01, 6'h0d, 8'h01 << i);
      chk(tb, (8'h01 << i) & 8'hef);
      chk({pc, pd}, (i == 2) ? {6'h15, 6'h0d} : 12'h000);
    end
    mr(2'b01, 6'h0e, 8'h25);
    chk({rng, lvl}, 7'h4d);
    mr(2'b01, 6'h0d, 8'h40);
    chk({rng, lvl}, 7'h25);
    mr(2'b01, 6'h0e, 8'h52);
    mr(2'b01, 6'h0e, 8'h73);
    chk(refw_n, 1);
    chk({rng, lvl}, 7'h25);
    mr(2'b00, 6'h0e, 8'h00);
    chk(s[15:8], 8'h52);
    mr(2'b01, 6'h0d, 8'hc4);
    chk({rng, lvl, pc, pd}, {7'h52, 6'h2a, 6'h12});
    mr(2'b01, 6'h0d, 8'h20);
    mr(2'b10, 6'h00, 8'h00);
    chk({s[1], mwok}, 2'b10);
    for (int j = 0; j < 32; j++) begin
      if (j % 16 == 0) mr(2'b01, 6'h0d, {3'b000, j[4], 4'h0});
      {base_bit, rr_raw} <= j[3:0];
      repeat (2) @(posedge aclk);
      chk(rr_rep, (base_bit && !j[4] && rr_raw inside {3'h1, 3'h2}) ? 3'h3 : rr_raw);
    end
    mr(2'b10, 6'h00, 8'h00);
    chk(s[1], 1'b0);
    chk(ill_n, 0);
    mr(2'b01, 6'h0d, 8'h01);
    axi_wr(32'h0000_0004, 32'h0000_2a00);
    chk(r, 2'h0);
    repeat (3) @(posedge aclk);
    axi_rd(32'h0000_0008);
    chk(s[21:16], 6'h2a);
    mr(2'b01, 6'h0d, 8'h00);
    chk(tb[0], 1'b0);
    axi_wr(32'h0000_0004, 32'h0000_0001);
    print_verdict();
  end
endmodule : dram_mode_reg_set_point_ctl_bench

// [verif/mrsp_link_props.sv]
// Link-side property checker for the mode-register set-point block.
`timescale 1ns/1ps
module mrsp_link_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cke,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic       cmd_masked_wr,
  input wire logic [5:0] cmd_addr,
  input wire logic [7:0] cmd_op,
  input wire logic [5:0] ca,
  input wire logic [7:0] dq_out,
  input wire logic       dq_oe,
  input wire logic       dq_valid
);
  logic [7:0] train_reg;     // Mirror of the training register.
  logic [6:0] copy_reg [2];  // Mirror of both set-point copies.
  logic       rd_dref_reg;   // A data-reference read was taken last cycle.
  logic       rd_other_reg;  // Any other read was taken last cycle.
  logic       echo_reg;      // Training with clock enable low last cycle.
  wire        take = cmd_valid && !cmd_masked_wr && !(train_reg[0] && !cke);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Refused commands leave the mirror alone, just as they must leave the device alone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      train_reg <= 8'h00;
      copy_reg[0] <= 7'h4d;
      copy_reg[1] <= 7'h4d;
    end else if (take && cmd_write && cmd_addr == 6'h0d) begin
      train_reg <= cmd_op;
    end else if (take && cmd_write && cmd_addr == 6'h0e && cmd_op[5:0] <= 6'h32) begin
      copy_reg[train_reg[6]] <= cmd_op[6:0];
    end
  end
  // Cause of each cycle the device may drive the data bus.
  always_ff @(posedge aclk) begin
    rd_dref_reg <= take && !cmd_write && cmd_addr == 6'h0e;
    rd_other_reg <= take && !cmd_write && cmd_addr != 6'h0e;
    echo_reg <= train_reg[0] && !cke;
  end
  a_read_answered: assert property (take && !cmd_write |=> dq_valid && dq_oe)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (dq_valid |-> rd_dref_reg || rd_other_reg)
    else $error("read data without a read");
  a_read_copy: assert property (rd_dref_reg |-> dq_out == {1'b0, copy_reg[train_reg[6]]})
    else $error("wrong set-point copy read");
  a_other_zero: assert property (rd_other_reg |-> dq_out == 8'h00)
    else $error("other read not zero");
  a_train_echo: assert property (echo_reg |-> dq_oe && dq_out == {2'b00, $past(ca)})
    else $error("pins not echoed in training");
  a_bus_released: assert property (dq_oe && !dq_valid |-> echo_reg)
    else $error("data bus driven without cause");
  a_cke_on_clear: assert property (cmd_valid && cmd_write && cmd_addr == 6'h0d && train_reg[0] |-> cke)
    else $error("training cleared with clock enable low");
  a_no_masked: assert property (cmd_valid && cmd_masked_wr |-> !train_reg[5])
    else $error("masked write while masking disabled");
  c_read_dref: cover property (rd_dref_reg);
  c_echo: cover property (echo_reg);
  c_masked: cover property (cmd_valid && cmd_masked_wr);
endmodule : mrsp_link_props
